// ### cswu_regs.vh
`ifndef CSWU_REGS_VH
`define CSWU_REGS_VH
// register indices; the byte address on the bus is four times the index
`define CSWU_OFF_LOWER 12'h3a2
`define CSWU_OFF_PERIPH 12'h3a4
`define CSWU_OFF_MID 12'h3a6
`define CSWU_OFF_AUX 12'h3a8
`define CSWU_OFF_STATUS 12'h3ac
// reset values
`define CSWU_LOWER_RST 16'h0f1b
`define CSWU_PERIPH_RST 16'h0073
`define CSWU_MID_RST 16'h7fdb
`define CSWU_AUX_RST 16'h8183
// field positions
`define CSWU_RDY_IGN 2
`define CSWU_WRANGE 3
`define CSWU_LDRAM 6
`define CSWU_MONLY 5
`define CSWU_PSPACE 6
// first-level timing
`define CSWU_WIN_BITS 8
`endif

// ### cswu_wait_ctr.v
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// wait-state counter for one bus cycle
// ----------------------------------------
module cswu_wait_ctr
(
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // cycle control
  input wire start,
  input wire [3:0] min_waits,
  input wire use_ready,
  input wire ready_in,
  // result
  output reg busy,
  output reg done
);
  reg [3:0] cnt_q;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= 4'h0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        cnt_q <= min_waits;
        busy <= 1'b1;
      end
      else if (busy)
      begin
        if (cnt_q != 4'h0)
          cnt_q <= cnt_q - 4'h1;
        else if (!use_ready || ready_in)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### cswu_top.v
// What this block does
// - lower region ready honoured: wait count is a minimum, ready extends.
// - lower ready_ignore_bit set: ready inputs ignored, wait count only.
// - lower DRAM enabled: ready inputs always ignored for lower cycles.
// - lower two-bit wait code gives 0..3 waits, resets to 3.
// - lower DRAM cycle access time set by the lower wait code.
// - periph base compared with A19..A11; I/O space forces base 19..16 zero.
// - eight contiguous 256-byte periph windows from the base.
// - periph over DRAM region wins and runs 16 bits wide.
// - periph selects enabled only after both periph and aux writes.
// - periph 0..3 waits: 0,1,2,3 or with range bit 5,7,9,15.
// - periph ready honoured: three-bit code is a minimum.
// - periph ready_ignore_bit set: ready inputs ignored for all eight selects.
// - mid selects enabled only after both mid and aux writes.
// - mid selects each cover one quarter of the block.
// - one shared base and wait setting for all four mid selects.
// - lower DRAM: lower select becomes row strobe, col_strobe_n both low; mid 1 and 2 held high.
// - first_select_covers_all: mid select 0 covers whole span.
// - space choice 0 decodes I/O, 1 decodes memory for periph selects.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "cswu_regs.vh"
module cswu_top
(
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // cpu bus cycle
  input wire [19:0] cpu_addr,
  input wire cpu_io,
  input wire cpu_start,
  output reg cpu_done,
  output reg cpu_x16,
  // external ready pins
  input wire sync_ready_in,
  input wire async_ready_in,
  // selects, active low
  output reg lower_region_select_n,
  output reg [3:0] mid_region_selects_n,
  output reg [7:0] periph_selects_n,
  output reg [1:0] col_strobe_n
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [15:0] lower_q;
  reg [15:0] periph_q;
  reg [15:0] mid_q;
  reg [15:0] aux_q;
  reg periph_wr_q, aux_p_wr_q, mid_wr_q, aux_m_wr_q;
  reg have_aw_q, have_w_q;
  reg [11:0] aw_q;
  reg [31:0] w_q;
  reg [3:0] ws_q;
  wire periph_en = periph_wr_q & aux_p_wr_q;
  wire mid_en = mid_wr_q & aux_m_wr_q;
  wire wr_go = have_aw_q & have_w_q & ~s_axi_bvalid;
  wire wr_hit = (aw_q == `CSWU_OFF_LOWER) || (aw_q == `CSWU_OFF_PERIPH) ||
    (aw_q == `CSWU_OFF_MID) || (aw_q == `CSWU_OFF_AUX);
  function [15:0] merge;
    input [15:0] old;
    input [31:0] nw;
    input [3:0] st;
    begin
      merge = {st[1] ? nw[15:8] : old[15:8], st[0] ? nw[7:0] : old[7:0]};
    end
  endfunction
  // ----------------------------------------
  // axi write
  // ----------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lower_q <= `CSWU_LOWER_RST;
      periph_q <= `CSWU_PERIPH_RST;
      mid_q <= `CSWU_MID_RST;
      aux_q <= `CSWU_AUX_RST;
      periph_wr_q <= 1'b0;
      aux_p_wr_q <= 1'b0;
      mid_wr_q <= 1'b0;
      aux_m_wr_q <= 1'b0;
      have_aw_q <= 1'b0;
      have_w_q <= 1'b0;
      aw_q <= 12'h000;
      w_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end
    else
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_awvalid && !have_aw_q && !s_axi_awready)
      begin
        s_axi_awready <= 1'b1;
        have_aw_q <= 1'b1;
        aw_q <= {2'b00, s_axi_awaddr[11:2]};
      end
      if (s_axi_wvalid && !have_w_q && !s_axi_wready)
      begin
        s_axi_wready <= 1'b1;
        have_w_q <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        have_aw_q <= 1'b0;
        have_w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
        case (aw_q)
          `CSWU_OFF_LOWER: lower_q <= merge(lower_q, w_q, ws_q) & 16'h70e7;
          `CSWU_OFF_PERIPH:
          begin
            periph_q <= merge(periph_q, w_q, ws_q) & 16'hff8f;
            periph_wr_q <= 1'b1;
          end
          `CSWU_OFF_MID:
          begin
            mid_q <= merge(mid_q, w_q, ws_q) & 16'hfe27;
            mid_wr_q <= 1'b1;
          end
          `CSWU_OFF_AUX:
          begin
            aux_q <= merge(aux_q, w_q, ws_q) & 16'h7f7f;
            aux_p_wr_q <= 1'b1;
            aux_m_wr_q <= 1'b1;
          end
          default: ;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  // ----------------------------------------
  // axi read
  // ----------------------------------------
  reg [15:0] rd_d;
  reg rd_hit;
  reg cyc_busy_q;
  always @*
  begin
    rd_hit = 1'b1;
    case ({2'b00, s_axi_araddr[11:2]})
      `CSWU_OFF_LOWER: rd_d = lower_q;
      `CSWU_OFF_PERIPH: rd_d = periph_q;
      `CSWU_OFF_MID: rd_d = mid_q;
      `CSWU_OFF_AUX: rd_d = aux_q;
      `CSWU_OFF_STATUS: rd_d = {13'h0000, cyc_busy_q, mid_en, periph_en};
      default:
      begin
        rd_d = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end
    else
    begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready)
      begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {16'h0000, rd_d};
        s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
  // ----------------------------------------
  // ready pin synchronisers
  // ----------------------------------------
  reg [2:0] sync_ready_in_q, async_ready_in_q;
  reg ready_q;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync_ready_in_q <= 3'b000;
      async_ready_in_q <= 3'b000;
      ready_q <= 1'b0;
    end
    else
    begin
      sync_ready_in_q <= {sync_ready_in_q[1:0], sync_ready_in};
      async_ready_in_q <= {async_ready_in_q[1:0], async_ready_in};
      if (sync_ready_in_q[2] == sync_ready_in_q[1] && async_ready_in_q[2] == async_ready_in_q[1])
        ready_q <= sync_ready_in_q[2] | async_ready_in_q[2];
    end
  end
  // ----------------------------------------
  // address decode
  // ----------------------------------------
  wire lower_dram = lower_q[`CSWU_LDRAM];
  wire [2:0] lub = lower_q[14:12];
  wire lower_hit = !cpu_io && cpu_addr[19] == 1'b0 &&
    ((cpu_addr[18:16] & ~lub) == 3'b000);
  wire pspace_mem = aux_q[`CSWU_PSPACE];
  wire [8:0] pbase = pspace_mem ? periph_q[15:7] :
    {4'h0, periph_q[11:7]};
  wire periph_hit = periph_en && (cpu_io != pspace_mem) &&
    cpu_addr[19:11] == pbase;
  wire [2:0] pidx = cpu_addr[10:8];
  reg [6:0] mblk;
  reg [1:0] mq;
  reg mid_hit;
  always @*
  begin
    mblk = aux_q[14:8];
    mq = cpu_addr[12:11];
    mid_hit = 1'b0;
    if (mblk[0]) mq = cpu_addr[12:11];
    else if (mblk[1]) mq = cpu_addr[13:12];
    else if (mblk[2]) mq = cpu_addr[14:13];
    else if (mblk[3]) mq = cpu_addr[15:14];
    else if (mblk[4]) mq = cpu_addr[16:15];
    else if (mblk[5]) mq = cpu_addr[17:16];
    else mq = cpu_addr[18:17];
    if (mid_en && !cpu_io)
      mid_hit = ((cpu_addr[19:13] ^ mid_q[15:9]) & ~(mblk - 7'd1)) == 7'd0;
  end
  // ----------------------------------------
  // wait selection
  // ----------------------------------------
  reg [3:0] min_w;
  reg use_rdy;
  reg [1:0] wc;
  always @*
  begin
    min_w = 4'h0;
    use_rdy = 1'b1;
    wc = periph_q[1:0];
    if (periph_hit)
    begin
      if (!periph_q[`CSWU_WRANGE])
        min_w = {2'b00, wc};
      else
        case (wc)
          2'b00: min_w = 4'd5;
          2'b01: min_w = 4'd7;
          2'b10: min_w = 4'd9;
          default: min_w = 4'd15;
        endcase
      use_rdy = !periph_q[`CSWU_RDY_IGN];
    end
    else if (lower_hit)
    begin
      min_w = {2'b00, lower_q[1:0]};
      use_rdy = !lower_q[`CSWU_RDY_IGN] && !lower_dram;
    end
    else if (mid_hit)
    begin
      min_w = {2'b00, mid_q[1:0]};
      use_rdy = !mid_q[`CSWU_RDY_IGN];
    end
  end
  // ----------------------------------------
  // bus cycle and selects
  // ----------------------------------------
  wire ctr_busy, ctr_done;
  cswu_wait_ctr u_wait
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(cpu_start),
    .min_waits(min_w),
    .use_ready(use_rdy),
    .ready_in(ready_q),
    .busy(ctr_busy),
    .done(ctr_done)
  );
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cpu_done <= 1'b0;
      cpu_x16 <= 1'b0;
      cyc_busy_q <= 1'b0;
      lower_region_select_n <= 1'b1;
      mid_region_selects_n <= 4'hf;
      periph_selects_n <= 8'hff;
      col_strobe_n <= 2'b11;
    end
    else
    begin
      cpu_done <= ctr_done;
      cyc_busy_q <= ctr_busy;
      if (cpu_start && !ctr_busy)
      begin
        periph_selects_n <= periph_hit ? ~(8'h01 << pidx) : 8'hff;
        cpu_x16 <= periph_hit ? 1'b1 : lower_hit && (lower_dram || !lower_q[5]);
        lower_region_select_n <= !(lower_hit && !periph_hit);
        col_strobe_n <= (lower_dram && lower_hit && !periph_hit) ? 2'b00 : 2'b11;
        if (mid_hit && !periph_hit)
          mid_region_selects_n <= ~((4'h1 << mq) |
            {3'b000, mid_q[`CSWU_MONLY]});
        else
          mid_region_selects_n <= 4'hf;
        if (lower_dram)
          mid_region_selects_n[2:1] <= 2'b11;
      end
      else if (ctr_done)
      begin
        lower_region_select_n <= 1'b1;
        mid_region_selects_n <= 4'hf;
        periph_selects_n <= 8'hff;
        col_strobe_n <= 2'b11;
      end
    end
  end
endmodule
`default_nettype wire

// ### cswu_asserts.sv
`timescale 1ns/100ps
`default_nettype none
`include "cswu_regs.vh"
// ----
// select and cycle checks
// ----
module cswu_asserts
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  // cpu side
  input wire logic cpu_done,
  input wire logic lower_region_select_n,
  input wire logic [3:0] mid_region_selects_n,
  input wire logic [7:0] periph_selects_n
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [2:0] seen_q;
  logic [11:0] aw_idx;
  assign aw_idx = {2'b00, s_axi_awaddr[11:2]};
  always @(posedge aclk)
    if (!aresetn)
      seen_q <= 3'b000;
    else if (s_axi_awvalid && s_axi_awready)
      seen_q <= seen_q | {aw_idx == `CSWU_OFF_MID, aw_idx == `CSWU_OFF_AUX,
        aw_idx == `CSWU_OFF_PERIPH};
  done_pulse_a: assert property (cpu_done |=> !cpu_done)
    else $error("done wider than one cycle");
  periph_gate_a: assert property (!(seen_q[0] && seen_q[1]) |-> &periph_selects_n)
    else $error("periph select before both writes");
  mid_gate_a: assert property (!(seen_q[2] && seen_q[1]) |->
    mid_region_selects_n[0] && mid_region_selects_n[3])
    else $error("mid select before both writes");
  periph_one_a: assert property ($countones(~periph_selects_n) <= 1)
    else $error("two periph selects low");
  mid_pair_a: assert property ($countones(~mid_region_selects_n) > 1 &&
    lower_region_select_n |-> !mid_region_selects_n[0])
    else $error("mid selects overlap");
  end_release_a: assert property (cpu_done |-> &periph_selects_n && lower_region_select_n)
    else $error("select held past done");
  lower_min_a: assert property ($fell(lower_region_select_n) |=> !lower_region_select_n)
    else $error("lower select too short");
  periph_wins_a: assert property (!lower_region_select_n |-> &periph_selects_n)
    else $error("lower and periph both low");
endmodule
`default_nettype wire

// ### cswu_ext_dev.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// external device holding off ready
// ----
module cswu_ext_dev
(
  // clock
  input wire logic aclk,
  // any select low when 0
  input wire logic sel_n,
  // stall length and pin choice
  input wire logic [7:0] dly,
  input wire logic pick,
  // ready pins
  output logic sync_ready_in,
  output logic async_ready_in
);
  logic [7:0] cnt_q;
  always @(posedge aclk)
    if (sel_n)
      cnt_q <= 8'h00;
    else if (cnt_q != 8'hff)
      cnt_q <= cnt_q + 8'h01;
  // ready deasserted when not addressed
  assign sync_ready_in = !sel_n && cnt_q >= dly && !pick;
  assign async_ready_in = !sel_n && cnt_q >= dly && pick;
endmodule
`default_nettype wire

// ### cswu_top_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "cswu_regs.vh"
// ----
// register and bus cycle tests
// ----
module cswu_top_test;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cpu_io;
  logic cpu_start, cpu_done, cpu_x16, sync_ready_in, async_ready_in, lower_region_select_n;
  logic pick, sel_n, ls, x16;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb, mid_region_selects_n, ms;
  logic [1:0] s_axi_bresp, s_axi_rresp, col_strobe_n, rs, cs;
  logic [19:0] cpu_addr;
  logic [7:0] periph_selects_n, dly, ps;
  int n_fail, n_checks, lat, base;
  int tab[8] = '{0, 1, 2, 3, 5, 7, 9, 15};
  cswu_top cswu_top_i (.*);
  cswu_ext_dev cswu_ext_dev_i (.*);
  assign sel_n = lower_region_select_n & (&mid_region_selects_n) & (&periph_selects_n);
  task chk(input logic [31:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %0t got %h want %h", $time, s, e);
    end
  endtask
  task wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] r);
    int t;
    t = 0;
    @(posedge aclk);
    s_axi_awaddr <= {a[9:0], 2'b00};
    s_axi_wdata <= {16'h0000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do
    begin
      @(posedge aclk);
      t++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && t < 50);
    s_axi_bready <= 1'b0;
    chk({s_axi_bvalid, s_axi_bresp}, {1'b1, r});
  endtask
  task rd(input logic [11:0] a);
    int t;
    t = 0;
    @(posedge aclk);
    s_axi_araddr <= {a[9:0], 2'b00};
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do
    begin
      @(posedge aclk);
      t++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && t < 50);
    s_axi_rready <= 1'b0;
    rdat = s_axi_rvalid ? s_axi_rdata : 32'hxxxx_xxxx;
    rs = s_axi_rresp;
  endtask
  task cyc(input logic [19:0] a, input logic io);
    @(posedge aclk);
    cpu_addr <= a;
    cpu_io <= io;
    cpu_start <= 1'b1;
    {ls, ps, ms, cs} = 15'h7fff;
    lat = 0;
    do
    begin
      @(posedge aclk);
      cpu_start <= 1'b0;
      lat++;
      ps &= periph_selects_n;
      ms &= mid_region_selects_n;
      ls &= lower_region_select_n;
      cs &= col_strobe_n;
    end
    while (cpu_done !== 1'b1 && lat < 300);
    x16 = cpu_x16;
    if (cpu_done !== 1'b1)
      n_fail++;
  endtask
  task report_and_stop;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial
  begin
    #400000;
    n_fail++;
    report_and_stop;
  end
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {cpu_start, cpu_io, pick, cpu_addr, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    dly = 8'h1e;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`CSWU_OFF_PERIPH);
    chk(rdat[15:0], 16'h0073);
    rd(`CSWU_OFF_MID);
    chk(rdat[15:0], 16'h7fdb);
    rd(`CSWU_OFF_LOWER);
    chk(rdat[15:0], 16'h0f1b);
    rd(12'h3b0);
    chk({rs, rdat[29:0]}, 32'h8000_0000);
    wr(12'h3b0, 16'h1234, 2'b10);
    wr(`CSWU_OFF_AUX, 16'h81c3, 2'b00);
    cyc(20'h0_0000, 1'b0);
    chk({ls, ps}, {1'b0, 8'hff});
    wr(`CSWU_OFF_PERIPH, 16'h2077, 2'b00);
    wr(`CSWU_OFF_AUX, 16'h8183, 2'b00);
    cyc(20'h0_0300, 1'b1);
    chk(ps, 8'hf7);
    wr(`CSWU_OFF_AUX, 16'h81c3, 2'b00);
    for (int i = 0; i < 8; i++)
    begin
      wr(`CSWU_OFF_PERIPH, 16'h2070 | {12'h000, i[2], 1'b1, i[1:0]}, 2'b00);
      cyc({9'h040, i[2:0], {8{i[0]}}}, 1'b0);
      if (i == 0)
        base = lat;
      chk(ps, 8'(~(8'h01 << i)));
      chk(lat, base + tab[i]);
    end
    wr(`CSWU_OFF_PERIPH, 16'h2071, 2'b00);
    cyc(20'h2_0000, 1'b0);
    chk(lat > base + 20, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      wr(`CSWU_OFF_LOWER, {14'h03c7, i[1:0]}, 2'b00);
      cyc(20'h0_0100, 1'b0);
      if (i == 0)
        base = lat;
      chk(ls, 1'b0);
      chk(lat, base + i);
    end
    pick <= 1'b1;
    wr(`CSWU_OFF_LOWER, 16'h0f19, 2'b00);
    cyc(20'h0_0100, 1'b0);
    chk(lat > base + 20 && lat < base + 45, 1'b1);
    pick <= 1'b0;
    dly <= 8'h00;
    cyc(20'h0_0100, 1'b0);
    chk(lat, base + 4);
    dly <= 8'h1e;
    wr(`CSWU_OFF_LOWER, 16'h0f5a, 2'b00);
    cyc(20'h0_0100, 1'b0);
    chk(lat, base + 2);
    chk(ls, 1'b0);
    chk(cs, 2'b00);
    wr(`CSWU_OFF_PERIPH, 16'h00f7, 2'b00);
    cyc(20'h0_0900, 1'b0);
    chk({ls, x16, ps}, {1'b1, 1'b1, 8'hfd});
    wr(`CSWU_OFF_LOWER, 16'h0f1c, 2'b00);
    wr(`CSWU_OFF_MID, 16'h41dc, 2'b00);
    for (int q = 0; q < 4; q++)
    begin
      cyc({7'h20, q[1:0], 11'h000}, 1'b0);
      chk(ms, 4'(~(4'h1 << q)));
      chk(lat, base);
    end
    wr(`CSWU_OFF_MID, 16'h41fc, 2'b00);
    cyc(20'h4_1000, 1'b0);
    chk(ms, 4'ha);
    report_and_stop;
  end
endmodule
bind cswu_top cswu_asserts cswu_asserts_i (.*);
`default_nettype wire
